// ### design/lfa_alu.sv
// lfa_alu: combinational result, flag and skip decode per operation
`timescale 1ns/1ps
module lfa_alu
  import lfa_pkg::*;
(
  input  wire logic [3:0] op_i,
  input  wire logic [7:0] w_i,
  input  wire logic [7:0] f_i,
  input  wire logic [7:0] lit_i,
  input  wire logic [2:0] bit_i,
  input  wire logic       dest_i,
  output logic      [7:0] res_o,
  output logic            c_o,
  output logic            dc_o,
  output logic            z_o,
  output logic            upd_c_o,
  output logic            upd_z_o,
  output logic            wr_w_o,
  output logic            wr_f_o,
  output logic            skip_o
);

  logic [8:0] sum;      // full sum with carry out of bit 7
  logic [4:0] nib_sum;  // low nibble sum with carry out of bit 3
  logic [7:0] addend;   // literal or file operand
  logic [7:0] bmask;    // one-hot selected bit

  assign addend  = (op_i == LFA_SUM_LITERAL_OP) ? lit_i : f_i;
  assign sum     = {1'b0, w_i} + {1'b0, addend};
  assign nib_sum = {1'b0, w_i[3:0]} + {1'b0, addend[3:0]};
  assign bmask   = 8'h01 << bit_i;

  // operation decode
  always_comb begin
    res_o   = 8'h00;
    c_o     = sum[8];
    dc_o    = nib_sum[4];
    upd_c_o = 1'b0;
    upd_z_o = 1'b0;
    wr_w_o  = 1'b0;
    wr_f_o  = 1'b0;
    skip_o  = 1'b0;
    case (op_i)
      LFA_SUM_LITERAL_OP: begin
        res_o   = sum[7:0];
        upd_c_o = 1'b1;
        upd_z_o = 1'b1;
        wr_w_o  = 1'b1;
      end
      LFA_SUM_REGISTER_OP: begin
        res_o   = sum[7:0];
        upd_c_o = 1'b1;
        upd_z_o = 1'b1;
        wr_w_o  = ~dest_i;
        wr_f_o  = dest_i;
      end
      LFA_MASK_LITERAL_OP: begin
        res_o   = w_i & lit_i;
        upd_z_o = 1'b1;
        wr_w_o  = 1'b1;
      end
      LFA_MASK_REGISTER_OP: begin
        res_o   = w_i & f_i;
        upd_z_o = 1'b1;
        wr_w_o  = ~dest_i;
        wr_f_o  = dest_i;
      end
      LFA_BIT_ZERO_OP: begin
        res_o  = f_i & ~bmask;
        wr_f_o = 1'b1;
      end
      LFA_BIT_ONE_OP: begin
        res_o  = f_i | bmask;
        wr_f_o = 1'b1;
      end
      LFA_SKIP_ON_ONE_OP: begin
        skip_o = f_i[bit_i];
      end
      LFA_SKIP_ON_ZERO_OP: begin
        skip_o = ~f_i[bit_i];
      end
      LFA_REGISTER_WIPE_OP: begin
        res_o   = 8'h00;
        upd_z_o = 1'b1;
        wr_f_o  = 1'b1;
      end
      default: begin
        res_o = 8'h00;  // unknown code does nothing
      end
    endcase
    z_o = (res_o == 8'h00);
  end

endmodule

// ### design/lfa_core.sv
// lfa_core: apb-controlled literal/file alu engine with bit ops and skip
`timescale 1ns/1ps
// How it works
// - add literal to accumulator, update c dc z
// - add accumulator and file, d selects destination
// - and accumulator with file, only zero flag
// - and literal into accumulator, only zero flag
// - clear chosen file bit, flags untouched
// - set chosen file bit, flags untouched
// - bit one skips next instruction, two cycles, three when taken
// - bit zero skips next instruction, two cycles, three when taken
// - wipe file register and set zero flag
// - port read-modify-write uses pin levels
// - taken test costs extra no-operation cycle
module lfa_core
  import lfa_pkg::*;
#(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input  wire logic          core_clk_i,
  input  wire logic          reset_i,
  input  wire logic          psel_i,
  input  wire logic          penable_i,
  input  wire logic          pwrite_i,
  input  wire logic [7:0]    paddr_i,
  input  wire logic [31:0]   pwdata_i,
  output logic      [31:0]   prdata_o,
  output logic               pready_o,
  output logic               pslverr_o,
  input  wire logic [DW-1:0] port_pins_i,
  output logic      [DW-1:0] port_latch_o,
  output logic               nop_cycle_o,
  output logic               busy_o
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  lfa_state_t      state_r;       // engine state
  lfa_state_t      state_nxt;     // next engine state
  logic [31:0]     cmd_r;         // last issued instruction word
  logic [7:0]      w_r;           // working accumulator
  logic            c_r;           // carry flag
  logic            dc_r;          // nibble_half_flag
  logic            z_r;           // zero flag
  logic            skip_r;        // last executed instruction asked for a skip
  logic            nop_r;         // high during the filler cycle
  logic            busy_r;        // engine running
  logic [AW-1:0]   fptr_r;        // file window pointer
  logic [DW-1:0]   port_r;        // port output latch
  logic [31:0]     prdata_r;      // apb read data
  logic            pready_r;      // apb ready
  logic            pslverr_r;     // apb error
  logic [DW-1:0]   sync1_r;       // pin sync stage 1
  logic [DW-1:0]   sync2_r;       // pin sync stage 2
  logic [DW-1:0]   sync3_r;       // pin sync stage 3
  logic [DW-1:0]   pins_r;        // debounced pin levels

  // instruction fields
  // decoded straight from the captured word, stable for the whole run
  wire  [3:0]      op_w   = cmd_r[LFA_OP_LSB +: 4];
  wire  [AW-1:0]   fa_w   = cmd_r[LFA_FA_LSB +: AW];
  wire  [7:0]      lit_w  = cmd_r[LFA_LIT_LSB +: 8];
  wire  [2:0]      bit_w  = cmd_r[LFA_BIT_LSB +: 3];
  wire             dest_w = cmd_r[LFA_DEST_BIT];

  // alu results
  logic [7:0]      alu_res;
  logic            alu_c;
  logic            alu_dc;
  logic            alu_z;
  logic            alu_upd_c;
  logic            alu_upd_z;
  logic            alu_wr_w;
  logic            alu_wr_f;
  logic            alu_skip;

  // memory port
  logic [DW-1:0]   mem_rdata;
  wire             engine_idle = (state_r == LFA_S_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  wire             apb_acc    = psel_i & penable_i & ~pready_r;  // first access cycle
  wire             apb_fin    = psel_i & penable_i & pready_r;   // completing edge
  // one hit per mapped word; anything else answers with an error
  wire             hit_cmd    = (paddr_i == LFA_OFF_CMD);
  wire             hit_status = (paddr_i == LFA_OFF_STATUS);
  wire             hit_wreg   = (paddr_i == LFA_OFF_WREG);
  wire             hit_fptr   = (paddr_i == LFA_OFF_FPTR);
  wire             hit_fdata  = (paddr_i == LFA_OFF_FDATA);
  wire             hit_any    = hit_cmd | hit_status | hit_wreg | hit_fptr | hit_fdata;
  // writes that change engine state are refused while it runs
  wire             wr_blocked = pwrite_i & ~engine_idle & (hit_cmd | hit_wreg | hit_fdata);
  wire             apb_err    = ~hit_any | wr_blocked;
  wire             apb_wr_ok  = apb_fin & pwrite_i & ~pslverr_r;
  wire             issue      = apb_wr_ok & hit_cmd;

  // port address reads take pin levels, not the latch
  wire             ptr_is_port = (fptr_r == LFA_PORT_ADDR[AW-1:0]);
  wire             fa_is_port  = (fa_w == LFA_PORT_ADDR[AW-1:0]);
  wire  [DW-1:0]   win_rdata   = ptr_is_port ? pins_r : mem_rdata;
  wire  [DW-1:0]   f_operand   = fa_is_port ? pins_r : mem_rdata;

  wire  [31:0]     status_word = {16'h0000, w_r, 3'b000, busy_r, skip_r, z_r, dc_r, c_r};
  wire  [31:0]     rd_mux      = hit_cmd    ? cmd_r :
                                 hit_status ? status_word :
                                 hit_wreg   ? {24'h000000, w_r} :
                                 hit_fptr   ? {{(32-AW){1'b0}}, fptr_r} :
                                 hit_fdata  ? {{(32-DW){1'b0}}, win_rdata} : 32'h0000_0000;

  // memory port sharing: engine owns it while running
  wire             exec_wr   = (state_r == LFA_S_EXEC) & alu_wr_f;
  wire             apb_mwr   = apb_wr_ok & hit_fdata;
  wire  [AW-1:0]   mem_addr  = engine_idle ? fptr_r : fa_w;
  wire             mem_we    = exec_wr | apb_mwr;
  wire  [DW-1:0]   mem_wdata = exec_wr ? alu_res : pwdata_i[DW-1:0];
  wire             port_we   = mem_we & (mem_addr == LFA_PORT_ADDR[AW-1:0]);

  ////////////////////////////////////////////////////////////////////////////
  // submodules

  lfa_file_mem #(
    .DW (DW),
    .AW (AW)
  ) u_mem (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .addr_i     (mem_addr),
    .we_i       (mem_we),
    .wdata_i    (mem_wdata),
    .rdata_o    (mem_rdata)
  );

  lfa_alu u_alu (
    .op_i    (op_w),
    .w_i     (w_r),
    .f_i     (f_operand),
    .lit_i   (lit_w),
    .bit_i   (bit_w),
    .dest_i  (dest_w),
    .res_o   (alu_res),
    .c_o     (alu_c),
    .dc_o    (alu_dc),
    .z_o     (alu_z),
    .upd_c_o (alu_upd_c),
    .upd_z_o (alu_upd_z),
    .wr_w_o  (alu_wr_w),
    .wr_f_o  (alu_wr_f),
    .skip_o  (alu_skip)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser, one per bit

  genvar gi;
  generate
    for (gi = 0; gi < DW; gi++) begin : g_sync
      // three stages; the level is taken once stages two and three agree
      always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
          sync3_r[gi] <= 1'b0;
          pins_r[gi]  <= 1'b0;
        end else begin
          sync1_r[gi] <= port_pins_i[gi];
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
          if (sync2_r[gi] == sync3_r[gi]) begin
            pins_r[gi] <= sync3_r[gi];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // engine sequencing

  // next state: fetch operand, execute, then a filler cycle on skip
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      LFA_S_IDLE: begin
        if (issue) begin
          state_nxt = LFA_S_FETCH;
        end
      end
      LFA_S_FETCH: begin
        state_nxt = LFA_S_EXEC;
      end
      LFA_S_EXEC: begin
        state_nxt = alu_skip ? LFA_S_NOP : LFA_S_IDLE;
      end
      LFA_S_NOP: begin
        state_nxt = LFA_S_IDLE;
      end
      default: begin
        state_nxt = LFA_S_IDLE;
      end
    endcase
  end

  // state, busy and filler-cycle flags
  // busy and nop follow the next state so they line up with it
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= LFA_S_IDLE;
      busy_r  <= 1'b0;
      nop_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r  <= (state_nxt != LFA_S_IDLE);
      nop_r   <= (state_nxt == LFA_S_NOP);
    end
  end

  // instruction word capture
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cmd_r <= LFA_CMD_RST;
    end else if (issue) begin
      cmd_r <= pwdata_i;
    end
  end

  // accumulator: software load or alu writeback
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      w_r <= LFA_W_RST;
    end else if (state_r == LFA_S_EXEC && alu_wr_w) begin
      w_r <= alu_res;
    end else if (apb_wr_ok && hit_wreg) begin
      w_r <= pwdata_i[7:0];
    end
  end

  // status flags, touched only where the operation affects them
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      c_r    <= 1'b0;
      dc_r   <= 1'b0;
      z_r    <= 1'b0;
      skip_r <= 1'b0;
    end else if (state_r == LFA_S_EXEC) begin
      if (alu_upd_c) begin
        c_r  <= alu_c;
        dc_r <= alu_dc;
      end
      if (alu_upd_z) begin
        z_r <= alu_z;
      end
      skip_r <= alu_skip;
    end
  end

  // file window pointer and port latch
  // the latch mirrors every file write at the port address, engine or software
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      fptr_r <= '0;
      port_r <= LFA_PORT_RST;
    end else begin
      if (apb_wr_ok && hit_fptr) begin
        fptr_r <= pwdata_i[AW-1:0];
      end
      if (port_we) begin
        port_r <= mem_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer: one wait state on every transfer

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r <= apb_acc;
      if (apb_acc) begin
        pslverr_r <= apb_err;
        prdata_r  <= pwrite_i ? 32'h0000_0000 : rd_mux;
      end else if (apb_fin) begin
        pslverr_r <= 1'b0;
        prdata_r  <= 32'h0000_0000;
      end
    end
  end

  // outputs leave straight from their flops
  assign prdata_o     = prdata_r;
  assign pready_o     = pready_r;
  assign pslverr_o    = pslverr_r;
  assign port_latch_o = port_r;
  assign nop_cycle_o  = nop_r;
  assign busy_o       = busy_r;

endmodule

// ### design/lfa_file_mem.sv
// lfa_file_mem: file register storage with registered read data
`timescale 1ns/1ps
module lfa_file_mem
  import lfa_pkg::*;
#(
  parameter int DW = 8,
  parameter int AW = 7
) (
  input  wire logic          core_clk_i,
  input  wire logic          reset_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic          we_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o
);

  logic [DW-1:0] mem [2**AW];  // storage array, no reset
  logic [DW-1:0] rdata_r;      // registered read port

  // write port
  always_ff @(posedge core_clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

  // read port, one cycle latency
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= mem[addr_i];
    end
  end

  assign rdata_o = rdata_r;

endmodule

// ### design/lfa_pkg.sv
// lfa_pkg: shared constants for the literal/file alu datapath
package lfa_pkg;

  // apb register byte offsets
  localparam logic [7:0] LFA_OFF_CMD    = 8'h00;  // instruction issue / last instruction
  localparam logic [7:0] LFA_OFF_STATUS = 8'h04;  // flags, busy, skip, accumulator
  localparam logic [7:0] LFA_OFF_WREG   = 8'h08;  // working accumulator
  localparam logic [7:0] LFA_OFF_FPTR   = 8'h0c;  // file window pointer
  localparam logic [7:0] LFA_OFF_FDATA  = 8'h10;  // file window data

  // instruction word field positions
  localparam int LFA_LIT_LSB  = 0;   // literal k, 8 bits
  localparam int LFA_FA_LSB   = 8;   // file address f, 7 bits
  localparam int LFA_DEST_BIT = 15;  // destination d
  localparam int LFA_BIT_LSB  = 16;  // bit select b, 3 bits
  localparam int LFA_OP_LSB   = 20;  // operation code, 4 bits

  // status word field positions
  localparam int LFA_ST_C    = 0;  // carry
  localparam int LFA_ST_DC   = 1;  // nibble_half_flag
  localparam int LFA_ST_Z    = 2;  // zero
  localparam int LFA_ST_SKIP = 3;  // last executed instruction skipped
  localparam int LFA_ST_BUSY = 4;  // engine running
  localparam int LFA_ST_W    = 8;  // accumulator copy, 8 bits

  // operation codes
  localparam logic [3:0] LFA_SUM_LITERAL_OP  = 4'h0;
  localparam logic [3:0] LFA_SUM_REGISTER_OP = 4'h1;
  localparam logic [3:0] LFA_MASK_LITERAL_OP = 4'h2;
  localparam logic [3:0] LFA_MASK_REGISTER_OP = 4'h3;
  localparam logic [3:0] LFA_BIT_ZERO_OP     = 4'h4;
  localparam logic [3:0] LFA_BIT_ONE_OP      = 4'h5;
  localparam logic [3:0] LFA_SKIP_ON_ONE_OP  = 4'h6;
  localparam logic [3:0] LFA_SKIP_ON_ZERO_OP = 4'h7;
  localparam logic [3:0] LFA_REGISTER_WIPE_OP = 4'h8;

  // reset values and fixed map entries
  localparam logic [7:0]  LFA_W_RST     = 8'h00;
  localparam logic [7:0]  LFA_PORT_RST  = 8'h00;
  localparam logic [31:0] LFA_CMD_RST   = 32'h0000_0000;
  localparam logic [6:0]  LFA_PORT_ADDR = 7'h06;  // file address of the i/o port

  // engine states
  typedef enum logic [1:0] {
    LFA_S_IDLE,
    LFA_S_FETCH,
    LFA_S_EXEC,
    LFA_S_NOP
  } lfa_state_t;

endpackage

// ### testbench/lfa_core_asserts.sv
// lfa_core_asserts: port-level apb and engine timing checks for lfa_core
`timescale 1ns/1ps
module lfa_core_asserts
  import lfa_pkg::*;
#(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input wire logic          core_clk_i,
  input wire logic          reset_i,
  input wire logic          psel_i,
  input wire logic          penable_i,
  input wire logic          pwrite_i,
  input wire logic [7:0]    paddr_i,
  input wire logic [31:0]   pwdata_i,
  input wire logic [31:0]   prdata_o,
  input wire logic          pready_o,
  input wire logic          pslverr_o,
  input wire logic [DW-1:0] port_pins_i,
  input wire logic [DW-1:0] port_latch_o,
  input wire logic          nop_cycle_o,
  input wire logic          busy_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////////////////////////////////////////
  // bus answer: exactly one wait state, one-cycle answer
  a_ready_one_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("pready not one cycle after access");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  a_rdata_quiet: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data outside answer cycle");
  a_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  ////////////////////////////////////////////////////////////////////////////
  // engine: started only by an accepted command write, two or three cycles
  a_busy_from_cmd: assert property ($rose(busy_o) |->
    $past(pready_o && pwrite_i && !pslverr_o && paddr_i == LFA_OFF_CMD))
    else $error("engine started without command write");
  a_busy_length: assert property ($rose(busy_o) |->
    busy_o [*2] ##1 (!busy_o || nop_cycle_o))
    else $error("engine run length wrong");
  a_nop_last: assert property (nop_cycle_o |-> busy_o ##1 (!busy_o && !nop_cycle_o))
    else $error("filler cycle not single and final");
  a_nop_place: assert property (nop_cycle_o |-> $past(busy_o, 2))
    else $error("filler cycle not after execute");
  a_latch_cause: assert property ($changed(port_latch_o) |->
    $past(busy_o) || $past(pready_o && pwrite_i))
    else $error("port latch changed without cause");
  // main scenarios reached
  c_nop: cover property (nop_cycle_o);
  c_err: cover property (pslverr_o);
  c_run: cover property ($rose(busy_o) ##2 !busy_o);
endmodule

bind lfa_core lfa_core_asserts #(.AW(AW), .DW(DW)) u_lfa_chk (
  .core_clk_i  (core_clk_i),
  .reset_i     (reset_i),
  .psel_i      (psel_i),
  .penable_i   (penable_i),
  .pwrite_i    (pwrite_i),
  .paddr_i     (paddr_i),
  .pwdata_i    (pwdata_i),
  .prdata_o    (prdata_o),
  .pready_o    (pready_o),
  .pslverr_o   (pslverr_o),
  .port_pins_i (port_pins_i),
  .port_latch_o(port_latch_o),
  .nop_cycle_o (nop_cycle_o),
  .busy_o      (busy_o)
);

// ### testbench/tb.sv
// tb: self-checking bench for lfa_core over apb
`timescale 1ns/1ps
module tb;
  import lfa_pkg::*;
  logic        core_clk_i;    // 40 mhz clock
  logic        reset_i;       // async reset
  logic        psel_i;
  logic        penable_i;
  logic        pwrite_i;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic [7:0]  port_pins_i;   // pin levels
  logic [7:0]  port_latch_o;
  logic        nop_cycle_o;
  logic        busy_o;
  int          n_fail;        // mismatches
  int          cmp_count;     // comparisons
  logic        ec;            // expected carry
  logic        edc;           // expected nibble_half_flag
  logic        ez;            // expected zero
  logic [31:0] rd;            // last read data
  logic        er;            // last error response
  ////////////////////////////////////////////////////////////////////////////
  lfa_core #(.AW(7), .DW(8)) dut (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .port_pins_i(port_pins_i),
    .port_latch_o(port_latch_o), .nop_cycle_o(nop_cycle_o), .busy_o(busy_o));
  // free-running clock
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // compare seen against expected
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int i;
    psel_i   <= 1'b1;
    pwrite_i <= wr;
    paddr_i  <= a;
    pwdata_i <= wd;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    for (i = 0; i < 10; i++) begin
      @(posedge core_clk_i);
      if (pready_o === 1'b1) break;
    end
    if (i == 10) begin
      n_fail++;
      $display("BAD %0t no pready", $time);
      end_sim();
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  // follow the engine until idle, counting filler cycles
  task automatic idle_wait(output int nops);
    int i;
    nops = 0;
    for (i = 0; i < 10; i++) begin
      if (busy_o !== 1'b1) break;
      if (nop_cycle_o === 1'b1) nops++;
      @(posedge core_clk_i);
    end
    if (i == 10) begin
      n_fail++;
      $display("BAD %0t engine hang", $time);
      end_sim();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // load w and one file register, run one instruction, check all results
  task automatic run_op(input logic [3:0] op, input logic [6:0] f, input logic d,
                        input logic [2:0] b, input logic [7:0] k,
                        input logic [7:0] w0, input logic [7:0] f0);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] opnd;
    logic [7:0] r;
    logic [7:0] ew;
    logic [7:0] ef;
    logic       esk;
    int         nops;
    apb(1'b1, LFA_OFF_WREG, {24'h0, w0});
    apb(1'b1, LFA_OFF_FPTR, {25'h0, f});
    apb(1'b1, LFA_OFF_FDATA, {24'h0, f0});
    apb(1'b1, LFA_OFF_CMD, {8'h0, op, 1'b0, b, d, f, k});
    idle_wait(nops);
    ew   = w0;
    ef   = f0;
    esk  = 1'b0;
    opnd = (op == LFA_SUM_LITERAL_OP || op == LFA_MASK_LITERAL_OP) ? k : f0;
    s    = {1'b0, w0} + {1'b0, opnd};
    h    = {1'b0, w0[3:0]} + {1'b0, opnd[3:0]};
    r    = (op <= LFA_SUM_REGISTER_OP) ? s[7:0] : (w0 & opnd);
    if (op <= LFA_MASK_REGISTER_OP) begin
      if (op <= LFA_SUM_REGISTER_OP) begin
        ec  = s[8];
        edc = h[4];
      end
      ez = (r == 8'h00);
      if (op[0] && d) ef = r;
      else ew = r;
    end
    case (op)
      LFA_BIT_ZERO_OP:      ef[b] = 1'b0;
      LFA_BIT_ONE_OP:       ef[b] = 1'b1;
      LFA_SKIP_ON_ONE_OP:   esk = f0[b];
      LFA_SKIP_ON_ZERO_OP:  esk = ~f0[b];
      LFA_REGISTER_WIPE_OP: begin
        ef = 8'h00;
        ez = 1'b1;
      end
      default: ;
    endcase
    apb(1'b0, LFA_OFF_WREG, 32'h0);
    chk(rd, {24'h0, ew}, "wreg");
    apb(1'b0, LFA_OFF_FDATA, 32'h0);
    chk(rd, {24'h0, ef}, "file");
    apb(1'b0, LFA_OFF_STATUS, 32'h0);
    chk({21'h0, rd[15:8], rd[2:0]}, {21'h0, ew, ez, edc, ec}, "flags");
    chk(32'(nops), {31'h0, esk}, "filler");
    chk({31'h0, rd[LFA_ST_BUSY]}, 32'h0, "idle");
    if (op == LFA_SKIP_ON_ONE_OP || op == LFA_SKIP_ON_ZERO_OP) begin
      chk({31'h0, rd[LFA_ST_SKIP]}, {31'h0, esk}, "skip");
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // reset state
  task automatic s_reset();
    apb(1'b0, LFA_OFF_STATUS, 32'h0);
    chk(rd, 32'h0, "status rst");
    chk({24'h0, port_latch_o}, 32'h0, "latch rst");
  endtask
  // adds with carry boundaries, then and ops that must keep c and dc
  task automatic s_arith();
    run_op(LFA_SUM_LITERAL_OP, 7'h00, 1'b0, 3'd0, 8'h01, 8'h0f, 8'h00);
    run_op(LFA_SUM_LITERAL_OP, 7'h00, 1'b0, 3'd0, 8'h01, 8'hff, 8'h00);
    run_op(LFA_SUM_REGISTER_OP, 7'h20, 1'b0, 3'd0, 8'h00, 8'h80, 8'h80);
    run_op(LFA_SUM_REGISTER_OP, 7'h7f, 1'b1, 3'd0, 8'h00, 8'h12, 8'h34);
    run_op(LFA_SUM_LITERAL_OP, 7'h00, 1'b0, 3'd0, 8'h88, 8'h88, 8'h00);
    run_op(LFA_MASK_LITERAL_OP, 7'h00, 1'b0, 3'd0, 8'h0f, 8'hf0, 8'h00);
    run_op(LFA_MASK_LITERAL_OP, 7'h00, 1'b0, 3'd0, 8'h3c, 8'hff, 8'h00);
    run_op(LFA_MASK_REGISTER_OP, 7'h21, 1'b1, 3'd0, 8'h00, 8'h55, 8'haa);
    run_op(LFA_MASK_REGISTER_OP, 7'h21, 1'b0, 3'd0, 8'h00, 8'hff, 8'h81);
  endtask
  // every bit index for clear, set and both skip polarities
  task automatic s_bits();
    logic [7:0] m;
    for (int i = 0; i < 8; i++) begin
      m = 8'h01 << i;
      run_op(LFA_BIT_ZERO_OP, 7'h7f, 1'b0, 3'(i), 8'h00, 8'h5a, 8'hff);
      run_op(LFA_BIT_ONE_OP, 7'h7f, 1'b0, 3'(i), 8'h00, 8'h5a, 8'h00);
      run_op(LFA_SKIP_ON_ONE_OP, 7'h40, 1'b0, 3'(i), 8'h00, 8'h5a, m);
      run_op(LFA_SKIP_ON_ONE_OP, 7'h40, 1'b0, 3'(i), 8'h00, 8'h5a, ~m);
      run_op(LFA_SKIP_ON_ZERO_OP, 7'h40, 1'b0, 3'(i), 8'h00, 8'h5a, m);
      run_op(LFA_SKIP_ON_ZERO_OP, 7'h40, 1'b0, 3'(i), 8'h00, 8'h5a, ~m);
    end
  endtask
  // wipe after zero flag was cleared
  task automatic s_wipe();
    run_op(LFA_SUM_LITERAL_OP, 7'h00, 1'b0, 3'd0, 8'h01, 8'h01, 8'h00);
    run_op(LFA_REGISTER_WIPE_OP, 7'h00, 1'b0, 3'd0, 8'h00, 8'h12, 8'ha5);
  endtask
  // bit set on the port takes pins, not the latch
  task automatic s_port();
    int n;
    apb(1'b1, LFA_OFF_FPTR, {25'h0, LFA_PORT_ADDR});
    apb(1'b1, LFA_OFF_FDATA, 32'hff);
    chk({24'h0, port_latch_o}, 32'hff, "latch write");
    port_pins_i <= 8'h0f;
    repeat (6) @(posedge core_clk_i);
    apb(1'b1, LFA_OFF_CMD, {8'h0, LFA_BIT_ONE_OP, 1'b0, 3'd7, 1'b0, LFA_PORT_ADDR, 8'h00});
    idle_wait(n);
    chk({24'h0, port_latch_o}, 32'h8f, "latch rmw");
    apb(1'b0, LFA_OFF_FDATA, 32'h0);
    chk(rd, 32'h0f, "pin read");
  endtask
  // unmapped access and a write while the engine runs
  task automatic s_refuse();
    int n;
    apb(1'b0, 8'h14, 32'h0);
    chk({rd[30:0], er}, 32'h1, "unmapped read");
    apb(1'b1, 8'h14, 32'h1);
    chk({31'h0, er}, 32'h1, "unmapped write");
    apb(1'b1, LFA_OFF_WREG, 32'h3c);
    apb(1'b1, LFA_OFF_FPTR, 32'h10);
    apb(1'b1, LFA_OFF_FDATA, 32'h01);
    apb(1'b1, LFA_OFF_CMD, {8'h0, LFA_SKIP_ON_ONE_OP, 1'b0, 3'd0, 1'b0, 7'h10, 8'h00});
    apb(1'b1, LFA_OFF_WREG, 32'h77);
    chk({31'h0, er}, 32'h1, "busy write");
    idle_wait(n);
    apb(1'b0, LFA_OFF_WREG, 32'h0);
    chk(rd, 32'h3c, "busy write ignored");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    reset_i     = 1'b1;
    psel_i      = 1'b0;
    penable_i   = 1'b0;
    pwrite_i    = 1'b0;
    paddr_i     = 8'h00;
    pwdata_i    = 32'h0;
    port_pins_i = 8'h00;
    n_fail      = 0;
    cmp_count   = 0;
    ec          = 1'b0;
    edc         = 1'b0;
    ez          = 1'b0;
    repeat (4) @(posedge core_clk_i);
    reset_i <= 1'b0;
    @(posedge core_clk_i);
    s_reset();
    s_arith();
    s_bits();
    s_wipe();
    s_port();
    s_refuse();
    end_sim();
  end
endmodule
